// *** include/dog_pkg.sv ***
// Constants shared by the deserializer output and GPIO control block
package dog_pkg;
  // Register byte addresses
  localparam logic [7:0] GPIO0_CFG_ADDR = 8'h1d;
  localparam logic [7:0] GPIO12_CFG_ADDR = 8'h1e;
  localparam logic [7:0] GPIO3_OUT4_CFG_ADDR = 8'h1f;
  localparam logic [7:0] OUT56_CFG_ADDR = 8'h20;
  localparam logic [7:0] OUT78_CFG_ADDR = 8'h21;
  localparam int CFG_REG_COUNT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Fields of one 4-bit pin control nibble
  localparam int NIB_W = 4;
  localparam int NIB_EN = 0;
  localparam int NIB_BACK = 1;
  localparam int NIB_FWD = 2;
  localparam int NIB_VAL = 3;
  // Documented example values
  localparam logic [7:0] GPIO3_FWD_VALUE = 8'h05;
  localparam logic [7:0] OUT8_HIGH_VALUE = 8'h90;
  localparam logic [7:0] OUT8_LOW_VALUE = 8'h10;
  // Pixel clock ranges, normal and low-rate mode
  localparam int PCLK_NORM_MIN_MHZ = 15;
  localparam int PCLK_NORM_MAX_MHZ = 85;
  localparam int PCLK_LOW_MIN_MHZ = 5;
  // Clock and oscillator
  localparam int REF_CLK_MHZ = 50;
  localparam int OSC_DIV_DEFAULT = 4;
  typedef enum logic [1:0] {LINK_OFF, LINK_ACQUIRE, LINK_LOCKED} dog_link_t;
endpackage

// *** core/dog_irq_fwd.sv ***
// Downstream interrupt synchroniser and forwarder
`timescale 1ns/1ns
`default_nettype none
module dog_irq_fwd (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic downstream_irq_in_n,
  input wire logic irq_ack,
  output logic host_irq_out_n
);
  logic sync_a;
  logic sync_b;
  logic prev_b;
  logic pending;
  wire logic fall = prev_b & ~sync_b;

  // Two-stage synchroniser ahead of the edge detector
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      prev_b <= 1'b1;
    end else begin
      sync_a <= downstream_irq_in_n;
      sync_b <= sync_a;
      prev_b <= sync_b;
    end
  end

  // Falling edge raises a request; set wins over acknowledge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (fall) begin
      pending <= 1'b1;
    end else if (irq_ack) begin
      pending <= 1'b0;
    end
  end

  assign host_irq_out_n = ~pending;

  a_edge_sets_req: assert property (@(posedge ref_clk) disable iff (rst)
    fall |=> !host_irq_out_n) else $error("falling edge did not raise request");
  a_rearm_edge: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pending) |-> $past(prev_b) && !$past(sync_b))
    else $error("request raised without a fresh falling edge");
endmodule
`default_nettype wire

// *** core/dog_top.sv ***
// Deserializer output state, GPIO, general output and interrupt control
`timescale 1ns/1ns
`default_nettype none
module dog_top #(
  parameter int GPIO_N = 4,
  parameter int GPO_N = 5,
  parameter int DATA_W = 24,
  parameter int OSC_DIV = dog_pkg::OSC_DIV_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic downstream_irq_in_n,
  input wire logic irq_ack,
  output logic host_irq_out_n,
  input wire logic power_down_n,
  input wire logic output_enable_pin,
  input wire logic output_state_select,
  input wire logic cdr_locked,
  output logic cdr_acquire_en,
  input wire logic mode_18bit_link,
  input wire logic low_rate_cfg,
  input wire logic low_rate_strap,
  output logic low_rate_select,
  input wire logic osc_out_enable,
  input wire logic [DATA_W-1:0] pixel_data,
  input wire logic pass_in,
  input wire logic [GPIO_N-1:0] fwd_gpio_level,
  output logic [GPIO_N-1:0] back_gpio_level,
  input wire logic [GPIO_N-1:0] gpio_in,
  output logic [GPIO_N-1:0] gpio_out,
  output logic [GPIO_N-1:0] gpio_oe_n,
  output logic [GPO_N-1:0] register_driven_out,
  output logic [GPO_N-1:0] register_driven_oe_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic lock_out,
  output logic lock_oe_n,
  output logic pass_out,
  output logic pass_oe_n,
  output logic clk_out,
  output logic clk_oe_n
);
  localparam int PIN_N = 4 + GPIO_N;
  localparam int CFG_W = dog_pkg::CFG_REG_COUNT * 8;

  logic [7:0] cfg [0:dog_pkg::CFG_REG_COUNT-1];
  logic [CFG_W-1:0] cfg_flat;
  logic [PIN_N-1:0] sync_a;
  logic [PIN_N-1:0] sync_b;
  logic pdn_s;
  logic oen_s;
  logic oss_s;
  logic strap_s;
  logic [GPIO_N-1:0] gpio_s;
  dog_pkg::dog_link_t link_state;
  dog_pkg::dog_link_t next_link_state;
  logic locked;
  logic outs_z;
  logic outs_valid;
  logic static_drive;
  logic pass_hold;
  logic lf_active;
  logic osc_tick;
  logic [7:0] osc_cnt;
  logic [7:0] reg_idx;
  logic [GPIO_N-1:0] gpio_drive;
  logic [GPIO_N-1:0] gpio_level;

  dog_irq_fwd u_irq (
    .ref_clk(ref_clk),
    .rst(rst),
    .downstream_irq_in_n(downstream_irq_in_n),
    .irq_ack(irq_ack),
    .host_irq_out_n(host_irq_out_n)
  );

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {gpio_in, low_rate_strap, output_state_select, output_enable_pin, power_down_n};
      sync_b <= sync_a;
    end
  end
  assign pdn_s = sync_b[0];
  assign oen_s = sync_b[1];
  assign oss_s = sync_b[2];
  assign strap_s = sync_b[3];
  assign gpio_s = sync_b[PIN_N-1:4];

  // Register port
  assign reg_idx = reg_addr - dog_pkg::GPIO0_CFG_ADDR;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < dog_pkg::CFG_REG_COUNT; i++) begin
        cfg[i] <= dog_pkg::CFG_RESET;
      end
    end else if (reg_wr_en && reg_idx < 8'(dog_pkg::CFG_REG_COUNT)) begin
      cfg[reg_idx[2:0]] <= reg_wdata;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_idx < 8'(dog_pkg::CFG_REG_COUNT)) begin
      reg_rdata <= cfg[reg_idx[2:0]];
    end else begin
      reg_rdata <= 8'h00;
    end
  end
  always_comb begin
    for (int i = 0; i < dog_pkg::CFG_REG_COUNT; i++) begin
      cfg_flat[i*8 +: 8] = cfg[i];
    end
  end

  // Link acquisition state
  always_comb begin
    next_link_state = link_state;
    case (link_state)
      dog_pkg::LINK_OFF: if (pdn_s) next_link_state = dog_pkg::LINK_ACQUIRE;
      dog_pkg::LINK_ACQUIRE: begin
        if (!pdn_s) next_link_state = dog_pkg::LINK_OFF;
        else if (cdr_locked) next_link_state = dog_pkg::LINK_LOCKED;
      end
      dog_pkg::LINK_LOCKED: begin
        if (!pdn_s) next_link_state = dog_pkg::LINK_OFF;
        else if (!cdr_locked) next_link_state = dog_pkg::LINK_ACQUIRE;
      end
      default: next_link_state = dog_pkg::LINK_OFF;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link_state <= dog_pkg::LINK_OFF;
    end else begin
      link_state <= next_link_state;
    end
  end
  assign locked = (link_state == dog_pkg::LINK_LOCKED);
  assign cdr_acquire_en = (link_state != dog_pkg::LINK_OFF);

  // Low-rate mode captured only while powered down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lf_active <= 1'b0;
    end else if (link_state == dog_pkg::LINK_OFF) begin
      lf_active <= low_rate_cfg | strap_s;
    end
  end
  assign low_rate_select = lf_active;

  // Output state decode
  assign outs_z = ~pdn_s | (~oen_s & oss_s);
  assign outs_valid = pdn_s & oen_s & oss_s & locked;
  assign static_drive = pdn_s & oen_s & ~oss_s & ~locked & osc_out_enable;

  // Internal oscillator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else if (osc_cnt == 8'(OSC_DIV - 1)) begin
      osc_cnt <= 8'h00;
      osc_tick <= ~osc_tick;
    end else begin
      osc_cnt <= osc_cnt + 8'h01;
    end
  end

  // Pass status held while the input is static
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pass_hold <= 1'b0;
    end else if (locked) begin
      pass_hold <= pass_in;
    end
  end

  // Parallel, lock, pass and clock outputs
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out <= '0;
      data_oe_n <= 1'b1;
      lock_out <= 1'b0;
      lock_oe_n <= 1'b1;
      pass_out <= 1'b0;
      pass_oe_n <= 1'b1;
      clk_out <= 1'b0;
      clk_oe_n <= 1'b1;
    end else begin
      data_out <= outs_valid ? pixel_data : '0;
      data_oe_n <= outs_z;
      lock_out <= locked;
      lock_oe_n <= ~pdn_s;
      pass_out <= (pdn_s & oen_s & oss_s) & (locked ? pass_in : pass_hold);
      pass_oe_n <= outs_z;
      clk_out <= outs_valid ? ~clk_out : (static_drive & osc_tick);
      clk_oe_n <= outs_z;
    end
  end

  // Low colour pins as GPIOs in 18-bit mode
  for (genvar g = 0; g < GPIO_N; g++) begin : g_gpio
    localparam int NI = (g == 0) ? 0 : g + 1;
    wire logic [3:0] nib = cfg_flat[NI*dog_pkg::NIB_W +: dog_pkg::NIB_W];
    wire logic en = mode_18bit_link & nib[dog_pkg::NIB_EN];
    assign gpio_drive[g] = ~mode_18bit_link | (en & ~nib[dog_pkg::NIB_BACK]);
    assign gpio_level[g] = ~mode_18bit_link ? pixel_data[g] :
      nib[dog_pkg::NIB_FWD] ? fwd_gpio_level[g] : nib[dog_pkg::NIB_VAL];
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        gpio_out[g] <= 1'b0;
        gpio_oe_n[g] <= 1'b1;
        back_gpio_level[g] <= 1'b0;
      end else begin
        gpio_out[g] <= outs_valid & gpio_level[g];
        gpio_oe_n[g] <= outs_z | ~gpio_drive[g];
        back_gpio_level[g] <= en & nib[dog_pkg::NIB_BACK] & gpio_s[g];
      end
    end
  end

  // Register-driven outputs, never from the link
  for (genvar o = 0; o < GPO_N; o++) begin : g_gpo
    wire logic [3:0] nib = cfg_flat[(o+5)*dog_pkg::NIB_W +: dog_pkg::NIB_W];
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        register_driven_out[o] <= 1'b0;
        register_driven_oe_n[o] <= 1'b1;
      end else begin
        register_driven_out[o] <= nib[dog_pkg::NIB_EN] & nib[dog_pkg::NIB_VAL];
        register_driven_oe_n[o] <= ~nib[dog_pkg::NIB_EN];
      end
    end
  end

  a_pd_all_z: assert property (@(posedge ref_clk) disable iff (rst)
    !pdn_s |=> data_oe_n && pass_oe_n && clk_oe_n && lock_oe_n)
    else $error("outputs driven during power-down");
  a_oen_low_zero: assert property (@(posedge ref_clk) disable iff (rst)
    pdn_s && !oen_s && !oss_s |=> !data_oe_n && data_out == '0 && !clk_out)
    else $error("outputs not low with enable low");
  a_valid_data: assert property (@(posedge ref_clk) disable iff (rst)
    outs_valid |=> data_out == $past(pixel_data) && !data_oe_n)
    else $error("valid data not passed");
  a_lock_high: assert property (@(posedge ref_clk) disable iff (rst)
    link_state == dog_pkg::LINK_ACQUIRE && pdn_s && cdr_locked |=> ##1 lock_out)
    else $error("lock not raised after acquisition");
  a_acquire_start: assert property (@(posedge ref_clk) disable iff (rst)
    link_state == dog_pkg::LINK_OFF && pdn_s |=> cdr_acquire_en ##1 !lock_out)
    else $error("acquisition did not start cleanly");
  a_pass_held: assert property (@(posedge ref_clk) disable iff (rst)
    pdn_s && oen_s && oss_s && !locked |=> pass_out == $past(pass_hold))
    else $error("pass status not held");
  a_out8_level: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr_en && reg_addr == dog_pkg::OUT78_CFG_ADDR && reg_wdata == dog_pkg::OUT8_HIGH_VALUE
    |=> ##1 register_driven_out[GPO_N-1] && !register_driven_oe_n[GPO_N-1])
    else $error("output eight not driven high");
  a_lf_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    link_state != dog_pkg::LINK_OFF && $past(link_state) != dog_pkg::LINK_OFF
    |-> $stable(lf_active)) else $error("low-rate mode changed while powered");
endmodule
`default_nettype wire

// *** verif/dog_far_model.sv ***
// Downstream partner model: interrupt source and GPIO pin partner
`timescale 1ns/1ns
`default_nettype none
module dog_far_model (
  input wire logic ref_clk,
  input wire logic raise,
  input wire logic clear,
  input wire logic [3:0] pin_lvl,
  input wire logic [3:0] gpio_oe_n,
  input wire logic [3:0] gpio_out,
  output logic irq_n,
  output logic [3:0] gpio_in
);
  logic held = 1'b0;
  // Request held until the controller clears the source
  always @(posedge ref_clk) begin
    if (clear) begin
      held <= 1'b0;
    end else if (raise) begin
      held <= 1'b1;
    end
  end
  assign irq_n = ~held;
  // Pin level from both drivers
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gpio_in[i] = gpio_oe_n[i] ? pin_lvl[i] : gpio_out[i];
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the output and GPIO control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
  num_errors++; $display("mismatch %s exp %h got %h", nm, exp, got); end end
module testbench;
  logic ref_clk, rst = 1'b1, reg_wr_en = 1'b0, irq_ack = 1'b0, raise = 1'b0;
  logic clear = 1'b0, power_down_n = 1'b0, output_enable_pin = 1'b1;
  logic output_state_select = 1'b1, cdr_locked = 1'b0, mode_18bit_link = 1'b0;
  logic low_rate_cfg = 1'b1, low_rate_strap = 1'b0, osc_out_enable = 1'b0;
  logic pass_in = 1'b1;
  logic clk_seen;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [23:0] pixel_data = 24'h5a3c96, data_out;
  logic [3:0] fwd_gpio_level = 4'h8, pin_lvl = 4'h8;
  logic [3:0] back_gpio_level, gpio_in, gpio_out, gpio_oe_n;
  logic [4:0] register_driven_out, register_driven_oe_n;
  logic downstream_irq_in_n, host_irq_out_n, cdr_acquire_en, low_rate_select;
  logic data_oe_n, lock_out, lock_oe_n, pass_out, pass_oe_n, clk_out, clk_oe_n;
  int num_errors = 0;
  int samples_checked = 0;
  dog_top uut (.ref_clk, .rst, .reg_wr_en, .reg_addr, .reg_wdata, .reg_rdata,
    .downstream_irq_in_n, .irq_ack, .host_irq_out_n, .power_down_n,
    .output_enable_pin, .output_state_select, .cdr_locked, .cdr_acquire_en,
    .mode_18bit_link, .low_rate_cfg, .low_rate_strap, .low_rate_select,
    .osc_out_enable, .pixel_data, .pass_in, .fwd_gpio_level, .back_gpio_level,
    .gpio_in, .gpio_out, .gpio_oe_n, .register_driven_out, .register_driven_oe_n,
    .data_out, .data_oe_n, .lock_out, .lock_oe_n, .pass_out, .pass_oe_n,
    .clk_out, .clk_oe_n);
  dog_far_model far (.ref_clk, .raise, .clear, .pin_lvl, .gpio_oe_n, .gpio_out,
    .irq_n(downstream_irq_in_n), .gpio_in);
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    settle(2);
    `CHK("reg_rdata", exp, reg_rdata)
  endtask
  // Select 0 raise, 1 clear, 2 acknowledge
  task automatic pulse(input int s);
    @(posedge ref_clk);
    {raise, clear, irq_ack} <= 3'b100 >> s;
    @(posedge ref_clk);
    {raise, clear, irq_ack} <= 3'b000;
  endtask
  task automatic wait_irq(input logic exp);
    for (int i = 0; i < 8 && host_irq_out_n !== exp; i++) begin
      settle(1);
    end
    `CHK("host_irq_out_n", exp, host_irq_out_n)
  endtask
  task automatic pd_cycle();
    @(posedge ref_clk);
    power_down_n <= 1'b0;
    settle(6);
    @(posedge ref_clk);
    power_down_n <= 1'b1;
    settle(6);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'h1d + 8'(i), dog_pkg::CFG_RESET);
    end
    `CHK("oe_n", 8'hff, {gpio_oe_n, data_oe_n, lock_oe_n, pass_oe_n, clk_oe_n})
    $display("test power down done");
    @(posedge ref_clk);
    power_down_n <= 1'b1;
    settle(6);
    `CHK("cdr_acquire_en", 1'b1, cdr_acquire_en)
    `CHK("lock_out", 1'b0, lock_out)
    `CHK("low_rate_select", 1'b1, low_rate_select)
    @(posedge ref_clk);
    cdr_locked <= 1'b1;
    low_rate_cfg <= 1'b0;
    settle(6);
    `CHK("lock_out", 1'b1, lock_out)
    `CHK("low_rate_select", 1'b1, low_rate_select)
    `CHK("data_out", pixel_data, data_out)
    `CHK("pass_out", 1'b1, pass_out)
    `CHK("gpio_out", pixel_data[3:0], gpio_out)
    clk_seen = clk_out;
    settle(1);
    `CHK("clk_out", ~clk_seen, clk_out)
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      output_enable_pin <= (k == 2);
      output_state_select <= (k == 0);
      settle(6);
      `CHK("data_oe_n", (k == 0), data_oe_n)
      `CHK("data_out", 24'h0, data_out & {24{k != 0}})
    end
    @(posedge ref_clk);
    output_state_select <= 1'b1;
    cdr_locked <= 1'b0;
    @(posedge ref_clk);
    pass_in <= 1'b0;
    settle(6);
    `CHK("static", 26'h1, {lock_out, data_out, pass_out})
    @(posedge ref_clk);
    output_state_select <= 1'b0;
    osc_out_enable <= 1'b1;
    settle(6);
    clk_seen = clk_out;
    settle(dog_pkg::OSC_DIV_DEFAULT);
    `CHK("clk_out osc", ~clk_seen, clk_out)
    `CHK("pass_out", 1'b0, pass_out)
    @(posedge ref_clk);
    output_state_select <= 1'b1;
    osc_out_enable <= 1'b0;
    pd_cycle();
    `CHK("low_rate_select", 1'b0, low_rate_select)
    @(posedge ref_clk);
    low_rate_strap <= 1'b1;
    pd_cycle();
    `CHK("low_rate_select", 1'b1, low_rate_select)
    $display("test output states done");
    @(posedge ref_clk);
    cdr_locked <= 1'b1;
    mode_18bit_link <= 1'b1;
    wr(dog_pkg::GPIO3_OUT4_CFG_ADDR, dog_pkg::GPIO3_FWD_VALUE);
    settle(6);
    `CHK("gpio3 fwd", 2'b01, {gpio_oe_n[3], gpio_out[3]})
    @(posedge ref_clk);
    fwd_gpio_level <= 4'h0;
    settle(6);
    `CHK("gpio3 fwd", 2'b00, {gpio_oe_n[3], gpio_out[3]})
    wr(dog_pkg::GPIO3_OUT4_CFG_ADDR, 8'h03);
    settle(6);
    `CHK("gpio3 back", 2'b11, {gpio_oe_n[3], back_gpio_level[3]})
    wr(dog_pkg::OUT78_CFG_ADDR, dog_pkg::OUT8_HIGH_VALUE);
    wr(8'h22, 8'hff);
    settle(3);
    `CHK("out8", 6'h2f, {register_driven_out[4], register_driven_oe_n})
    rd(dog_pkg::OUT78_CFG_ADDR, 8'h90);
    rd(8'h22, 8'h00);
    @(posedge ref_clk);
    fwd_gpio_level <= 4'hf;
    wr(dog_pkg::OUT78_CFG_ADDR, dog_pkg::OUT8_LOW_VALUE);
    settle(3);
    `CHK("out8", 6'h0f, {register_driven_out[4], register_driven_oe_n})
    $display("test gpio done");
    pulse(0);
    settle(1);
    `CHK("host_irq_out_n", 1'b1, host_irq_out_n)
    wait_irq(1'b0);
    pulse(2);
    settle(6);
    `CHK("host_irq_out_n", 1'b1, host_irq_out_n)
    pulse(1);
    settle(3);
    pulse(0);
    wait_irq(1'b0);
    pulse(2);
    wait_irq(1'b1);
    $display("test interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
